//--- design/boxu_top.sv
// Byte operation execute unit: sum/mask byte ops, destination select and side effects
//
// Contract
// - PC writes except absolute jump clear the ninth bit (bit 8)
// - Port self-modify reads pin levels, not latch
// - Direction load 5/6/7 copies accumulator to bank
// - Direction bit one floats pin, output off
// - Tick counter write clears assigned prescaler
// - Add accumulator and register, update C/DC/Z
// - Target bit zero accumulator, one register
// - Literal AND into accumulator, zero flag only
`timescale 1ns/10ps
`default_nettype none
module boxu_top
    import boxu_pkg::*;
(
    input  wire logic              CLK,               // Core instruction clock, 100 MHz
    input  wire logic              RESET,             // Synchronous reset, active high
    input  wire logic              INSTR_VALID,       // Instruction word valid this cycle
    input  wire logic [11:0]       INSTR,             // Twelve bit instruction word
    input  wire logic [7:0]        REG_RDATA,         // Addressed file register contents
    input  wire logic              PRESCALER_ON_TICK, // Prescaler assigned to tick counter
    input  wire logic [7:0]        PIN_A_IN,          // Bank A pin levels (async)
    input  wire logic [7:0]        PIN_B_IN,          // Bank B pin levels (async)
    input  wire logic [7:0]        PIN_C_IN,          // Bank C pin levels (async)
    input  wire logic              STATUS_CARRY_IN,   // Current carry flag
    input  wire logic              STATUS_NIB_IN,     // Current nibble overflow flag
    input  wire logic              STATUS_ZERO_IN,    // Current zero flag
    output logic [4:0]             REG_ADDR,          // Register address, registered
    output logic                   REG_WE,            // Register write strobe
    output logic [7:0]             REG_WDATA,         // Register write data
    output logic                   PC_WRITE,          // Program counter write pulse
    output logic                   PC_BIT8_FORCE,     // Forced value of ninth PC bit
    output logic [7:0]             ACC,               // Accumulator
    output logic                   FLAG_CARRY,        // Carry flag
    output logic                   FLAG_NIB,          // Nibble overflow flag
    output logic                   FLAG_ZERO,         // Zero flag
    output logic                   PRESCALER_CLR,     // Prescaler clear pulse
    output logic [7:0]             DIR_A,             // Bank A direction latches
    output logic [7:0]             DIR_B,             // Bank B direction latches
    output logic [7:0]             DIR_C,             // Bank C direction latches
    output logic [7:0]             PIN_A_OE_N,        // Bank A output enable, low drives
    output logic [7:0]             PIN_B_OE_N,        // Bank B output enable, low drives
    output logic [7:0]             PIN_C_OE_N         // Bank C output enable, low drives
);

    // ****************************************************************
    // Functions
    // ****************************************************************

    // Eight-bit add with carries out of bit 7 and bit 3
    function automatic boxu_result_t do_sum(input logic [7:0] a, input logic [7:0] b);
        logic [8:0]   full;
        logic [4:0]   low;
        boxu_result_t r;
        full = {1'b0, a} + {1'b0, b};
        low = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        r.value = full[7:0];
        r.carry = full[BYTE_CARRY_BIT];
        r.nib_carry = low[NIB_CARRY_BIT];
        r.zero = (full[7:0] == BYTE_ZERO);
        return r;
    endfunction

    // Byte AND, only the zero flag is meaningful
    function automatic boxu_result_t do_mask(input logic [7:0] a, input logic [7:0] b);
        boxu_result_t r;
        r.value = a & b;
        r.carry = 1'b0;
        r.nib_carry = 1'b0;
        r.zero = ((a & b) == BYTE_ZERO);
        return r;
    endfunction

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [7:0] pa_s1_reg, pa_s2_reg, pb_s1_reg, pb_s2_reg, pc_s1_reg, pc_s2_reg;

    // Two stages since pins are asynchronous; only the second stage is read
    always_ff @(posedge CLK) begin
        pa_s1_reg <= PIN_A_IN;
        pa_s2_reg <= pa_s1_reg;
        pb_s1_reg <= PIN_B_IN;
        pb_s2_reg <= pb_s1_reg;
        pc_s1_reg <= PIN_C_IN;
        pc_s2_reg <= pc_s1_reg;
    end

    // ****************************************************************
    // Decode
    // ****************************************************************
    boxu_op_t   op;
    logic [4:0] faddr;
    logic       dest_reg;
    logic [7:0] operand;
    logic       pc_target;

    // Classify the instruction and select the file operand
    always_comb begin
        faddr = INSTR[4:0];
        dest_reg = INSTR[DEST_BIT];
        op = OP_NONE;
        if (INSTR_VALID) begin
            if (INSTR[11:6] == OPC_SUM_INTO_TARGET) begin
                op = OP_SUM;
            end else if (INSTR[11:6] == OPC_MASK_REGISTER_OP) begin
                op = OP_MASKR;
            end else if (INSTR[11:8] == OPC_MASK_WITH_LITERAL) begin
                op = OP_MASKL;
            end else if (INSTR[11:3] == OPC_PIN_DIR_LOAD) begin
                op = OP_DIR;
            end
        end
        // A port read as its own operand sees the pins, not the latch
        case (faddr)
            ADDR_IO_BANK_A: operand = pa_s2_reg;
            ADDR_IO_BANK_B: operand = pb_s2_reg;
            ADDR_IO_BANK_C: operand = pc_s2_reg;
            default:        operand = REG_RDATA;
        endcase
        // Control transfers other than the absolute jump rewrite the PC
        pc_target = INSTR_VALID && (INSTR[11:9] == OPC_CALL_TOP);
    end

    // ****************************************************************
    // Execute
    // ****************************************************************
    boxu_result_t res;
    logic [7:0]   acc_reg, acc_next;
    logic         c_reg, c_next, dc_reg, dc_next, z_reg, z_next;
    logic [4:0]   addr_reg, addr_next;
    logic         we_reg, we_next;
    logic [7:0]   wdata_reg, wdata_next;
    logic         pcw_reg, pcw_next;
    logic         pclr_reg, pclr_next;
    logic [7:0]   dira_reg, dira_next, dirb_reg, dirb_next, dirc_reg, dirc_next;
    logic         file_write;

    // Next state of accumulator, flags, register write and side effects
    always_comb begin
        acc_next = acc_reg;
        c_next = c_reg;
        dc_next = dc_reg;
        z_next = z_reg;
        addr_next = faddr;
        we_next = 1'b0;
        wdata_next = wdata_reg;
        pcw_next = 1'b0;
        dira_next = dira_reg;
        dirb_next = dirb_reg;
        dirc_next = dirc_reg;
        res = do_mask(acc_reg, INSTR[7:0]);
        case (op)
            OP_SUM: begin
                res = do_sum(acc_reg, operand);
                c_next = res.carry;
                dc_next = res.nib_carry;
                z_next = res.zero;
            end
            OP_MASKR: begin
                res = do_mask(acc_reg, operand);
                z_next = res.zero;
            end
            OP_MASKL: begin
                res = do_mask(acc_reg, INSTR[7:0]);
                z_next = res.zero;
                acc_next = res.value;
            end
            OP_DIR: begin
                case (INSTR[2:0])
                    ADDR_IO_BANK_A[2:0]: dira_next = acc_reg;
                    ADDR_IO_BANK_B[2:0]: dirb_next = acc_reg;
                    ADDR_IO_BANK_C[2:0]: dirc_next = acc_reg;
                    default: ;
                endcase
            end
            OP_NONE: ;
            default: ;
        endcase
        file_write = 1'b0;
        if (op == OP_SUM || op == OP_MASKR) begin
            if (dest_reg) begin
                file_write = 1'b1;
                we_next = 1'b1;
                wdata_next = res.value;
            end else begin
                acc_next = res.value;
            end
        end
        // Writing the PC low byte is a computed jump; so are call and return
        pcw_next = pc_target || (file_write && faddr == ADDR_PC_LOW);
        // Tick counter written by a marked op with d = 1
        pclr_next = file_write && (faddr == ADDR_TICK_COUNTER) && PRESCALER_ON_TICK;
    end

    // Register state; direction latches reset to all inputs
    always_ff @(posedge CLK) begin
        if (RESET) begin
            acc_reg <= RST_ACC;
            c_reg <= 1'b0;
            dc_reg <= 1'b0;
            z_reg <= 1'b0;
            addr_reg <= 5'h00;
            we_reg <= 1'b0;
            wdata_reg <= BYTE_ZERO;
            pcw_reg <= 1'b0;
            pclr_reg <= 1'b0;
            dira_reg <= RST_DIR;
            dirb_reg <= RST_DIR;
            dirc_reg <= RST_DIR;
        end else begin
            acc_reg <= acc_next;
            c_reg <= c_next;
            dc_reg <= dc_next;
            z_reg <= z_next;
            addr_reg <= addr_next;
            we_reg <= we_next;
            wdata_reg <= wdata_next;
            pcw_reg <= pcw_next;
            pclr_reg <= pclr_next;
            dira_reg <= dira_next;
            dirb_reg <= dirb_next;
            dirc_reg <= dirc_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    // All outputs but the constant-low PC_BIT8_FORCE are flops; OE is the latch itself, so a one floats the pin
    assign REG_ADDR = addr_reg;
    assign REG_WE = we_reg;
    assign REG_WDATA = wdata_reg;
    assign PC_WRITE = pcw_reg;
    assign PC_BIT8_FORCE = 1'b0 & pcw_reg;              // Ninth bit always written low
    assign ACC = acc_reg;
    assign FLAG_CARRY = c_reg;
    assign FLAG_NIB = dc_reg;
    assign FLAG_ZERO = z_reg;
    assign PRESCALER_CLR = pclr_reg;
    assign DIR_A = dira_reg;
    assign DIR_B = dirb_reg;
    assign DIR_C = dirc_reg;
    assign PIN_A_OE_N = dira_reg;
    assign PIN_B_OE_N = dirb_reg;
    assign PIN_C_OE_N = dirc_reg;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_sum_to_reg;
        INSTR_VALID && INSTR[11:6] == OPC_SUM_INTO_TARGET && INSTR[DEST_BIT];
    endsequence

    a_sum_writes_reg: assert property (@(posedge CLK) disable iff (RESET)
        s_sum_to_reg |=> REG_WE && REG_WDATA == $past(ACC) + $past(operand))
        else $error("sum to register not written");
    a_sum_carry: assert property (@(posedge CLK) disable iff (RESET)
        INSTR_VALID && INSTR[11:6] == OPC_SUM_INTO_TARGET
        |=> FLAG_CARRY == (({1'b0, $past(ACC)} + {1'b0, $past(operand)}) > 9'h0ff))
        else $error("sum carry wrong");
    a_sum_nibble: assert property (@(posedge CLK) disable iff (RESET)
        INSTR_VALID && INSTR[11:6] == OPC_SUM_INTO_TARGET
        |=> FLAG_NIB == (({1'b0, $past(ACC[3:0])} + {1'b0, $past(operand[3:0])}) > 5'h0f))
        else $error("nibble carry wrong");
    a_lit_mask: assert property (@(posedge CLK) disable iff (RESET)
        INSTR_VALID && INSTR[11:8] == OPC_MASK_WITH_LITERAL
        |=> ACC == ($past(ACC) & $past(INSTR[7:0])) && FLAG_ZERO == (ACC == BYTE_ZERO)
            && $stable(FLAG_CARRY) && !REG_WE)
        else $error("literal mask wrong");
    a_reg_mask_acc: assert property (@(posedge CLK) disable iff (RESET)
        INSTR_VALID && INSTR[11:6] == OPC_MASK_REGISTER_OP && !INSTR[DEST_BIT]
        |=> ACC == ($past(ACC) & $past(operand)) && !REG_WE && $stable(FLAG_NIB))
        else $error("register mask to accumulator wrong");
    // Pin level three edges back: two synchroniser stages plus the execute edge
    a_port_pins: assert property (@(posedge CLK) disable iff (RESET)
        INSTR_VALID && INSTR[11:6] == OPC_SUM_INTO_TARGET && !INSTR[DEST_BIT] && INSTR[4:0] == ADDR_IO_BANK_B
        |=> ACC == $past(ACC) + $past(PIN_B_IN, 3))
        else $error("port operand not from pins");
    a_dir_load: assert property (@(posedge CLK) disable iff (RESET)
        INSTR_VALID && INSTR == {OPC_PIN_DIR_LOAD, ADDR_IO_BANK_C[2:0]}
        |=> DIR_C == $past(ACC) && PIN_C_OE_N == DIR_C)
        else $error("direction load wrong");
    a_prescale_clr: assert property (@(posedge CLK) disable iff (RESET)
        s_sum_to_reg ##0 (INSTR[4:0] == ADDR_TICK_COUNTER && PRESCALER_ON_TICK)
        |=> PRESCALER_CLR)
        else $error("prescaler not cleared");
    a_prescale_only: assert property (@(posedge CLK) disable iff (RESET)
        PRESCALER_CLR |-> $past(INSTR_VALID && INSTR[DEST_BIT] && INSTR[4:0] == ADDR_TICK_COUNTER
            && PRESCALER_ON_TICK && (INSTR[11:6] == OPC_SUM_INTO_TARGET || INSTR[11:6] == OPC_MASK_REGISTER_OP)))
        else $error("prescaler cleared without tick counter write");
    a_pc_bit8: assert property (@(posedge CLK) disable iff (RESET)
        PC_WRITE |-> !PC_BIT8_FORCE && $past(INSTR[11:9]) != OPC_ABS_JUMP)
        else $error("pc ninth bit not forced low");

endmodule
`default_nettype wire

//--- include/boxu_pkg.sv
// Package for the byte operation execute unit: encodings, addresses, field layouts
package boxu_pkg;
    // ****************************************************************
    // Instruction encodings
    // ****************************************************************
    localparam logic [5:0] OPC_SUM_INTO_TARGET   = 6'h07; // 0001 11
    localparam logic [5:0] OPC_MASK_REGISTER_OP  = 6'h05; // 0001 01
    localparam logic [3:0] OPC_MASK_WITH_LITERAL = 4'he;  // 1110
    localparam logic [8:0] OPC_PIN_DIR_LOAD      = 9'h000; // 0000 0000 0
    localparam logic [2:0] OPC_ABS_JUMP          = 3'h5;  // 101
    localparam logic [2:0] OPC_CALL_TOP          = 3'h4;  // 100x: call / return-literal
    // ****************************************************************
    // Register file addresses
    // ****************************************************************
    localparam logic [4:0] ADDR_TICK_COUNTER = 5'h01;
    localparam logic [4:0] ADDR_PC_LOW       = 5'h02;
    localparam logic [4:0] ADDR_IO_BANK_A    = 5'h05;
    localparam logic [4:0] ADDR_IO_BANK_B    = 5'h06;
    localparam logic [4:0] ADDR_IO_BANK_C    = 5'h07;
    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int          PC_W            = 11;
    localparam int          PC_FORCED_BIT   = 8;   // Ninth bit of the program counter
    localparam int          NIB_CARRY_BIT   = 4;
    localparam int          BYTE_CARRY_BIT  = 8;
    localparam int          DEST_BIT        = 5;
    localparam logic [7:0]  RST_ACC         = 8'h00;
    localparam logic [7:0]  RST_DIR         = 8'hff;   // All pins high impedance
    localparam logic [7:0]  BYTE_ZERO       = 8'h00;

    // Result carrier: ALU value plus the flags it produces
    typedef struct packed {
        logic [7:0] value;
        logic       carry;
        logic       nib_carry;
        logic       zero;
    } boxu_result_t;

    // Decoded operation class
    typedef enum logic [4:0] {
        OP_NONE  = 5'b00001,
        OP_SUM   = 5'b00010,
        OP_MASKR = 5'b00100,
        OP_MASKL = 5'b01000,
        OP_DIR   = 5'b10000
    } boxu_op_t;
endpackage

//--- test/boxu_top_tb.sv
// Self-checking testbench for the byte operation execute unit
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module boxu_top_tb;
    import boxu_pkg::*;
    // ****************************************************************
    // Stimulus signals, model state and counters
    // ****************************************************************
    logic        CLK = 1'b0, RESET = 1'b1, INSTR_VALID = 1'b0, PRESCALER_ON_TICK = 1'b0;
    logic [11:0] INSTR = 12'h000;
    logic [7:0]  REG_RDATA = 8'h00, PIN_A_IN = 8'h00, PIN_B_IN = 8'h00, PIN_C_IN = 8'h00;
    logic [4:0]  REG_ADDR;
    logic        REG_WE, PC_WRITE, PC_BIT8_FORCE, FLAG_CARRY, FLAG_NIB, FLAG_ZERO, PRESCALER_CLR;
    logic [7:0]  REG_WDATA, ACC, DIR_A, DIR_B, DIR_C, PIN_A_OE_N, PIN_B_OE_N, PIN_C_OE_N;
    logic [7:0]  acc_m, wd_m;
    logic [7:0]  dir_m [0:2];
    logic        c_m, n_m, z_m;
    int          n_fail = 0, checks_done = 0, cycles = 0;

    boxu_top dut_u (.CLK(CLK), .RESET(RESET), .INSTR_VALID(INSTR_VALID), .INSTR(INSTR), .REG_RDATA(REG_RDATA),
        .PRESCALER_ON_TICK(PRESCALER_ON_TICK), .PIN_A_IN(PIN_A_IN), .PIN_B_IN(PIN_B_IN), .PIN_C_IN(PIN_C_IN),
        .STATUS_CARRY_IN(1'b0), .STATUS_NIB_IN(1'b0), .STATUS_ZERO_IN(1'b0), .REG_ADDR(REG_ADDR),
        .REG_WE(REG_WE), .REG_WDATA(REG_WDATA), .PC_WRITE(PC_WRITE), .PC_BIT8_FORCE(PC_BIT8_FORCE),
        .ACC(ACC), .FLAG_CARRY(FLAG_CARRY), .FLAG_NIB(FLAG_NIB), .FLAG_ZERO(FLAG_ZERO),
        .PRESCALER_CLR(PRESCALER_CLR), .DIR_A(DIR_A), .DIR_B(DIR_B), .DIR_C(DIR_C),
        .PIN_A_OE_N(PIN_A_OE_N), .PIN_B_OE_N(PIN_B_OE_N), .PIN_C_OE_N(PIN_C_OE_N));

    // ****************************************************************
    // Clock and hang guard
    // ****************************************************************
    always #5 CLK = ~CLK;
    // A run of this length needs well under a few hundred cycles
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 1000) begin
            n_fail++;
            $display("unexpected timeout exp %h got %h", 0, cycles);
            finish_test();
        end
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    // Compare every output against the model; pulses are looked at in their only cycle
    task automatic check_state(input logic we_e, input logic pcw_e, input logic clr_e, input logic [4:0] ad_e);
        `CHK("acc", acc_m, ACC)
        `CHK("carry", c_m, FLAG_CARRY)
        `CHK("nib", n_m, FLAG_NIB)
        `CHK("zero", z_m, FLAG_ZERO)
        `CHK("reg_we", we_e, REG_WE)
        `CHK("reg_wdata", wd_m, REG_WDATA)
        `CHK("reg_addr", ad_e, REG_ADDR)
        `CHK("pc_write", pcw_e, PC_WRITE)
        `CHK("pc_bit8", 1'b0, PC_BIT8_FORCE)
        `CHK("presc_clr", clr_e, PRESCALER_CLR)
        `CHK("dir", {dir_m[0], dir_m[1], dir_m[2]}, {DIR_A, DIR_B, DIR_C})
        `CHK("oe_n", {dir_m[0], dir_m[1], dir_m[2]}, {PIN_A_OE_N, PIN_B_OE_N, PIN_C_OE_N})
    endtask

    // Reset for four cycles, then expect the documented idle state
    task automatic do_reset();
        RESET <= 1'b1;
        repeat (4) @(posedge CLK);
        RESET <= 1'b0;
        #1;
        acc_m = RST_ACC;
        wd_m = BYTE_ZERO;
        {c_m, n_m, z_m} = 3'b000;
        dir_m = '{RST_DIR, RST_DIR, RST_DIR};
        check_state(1'b0, 1'b0, 1'b0, 5'h00);
    endtask

    // Execute one instruction and check its effects one cycle later
    task automatic run(input logic [11:0] ins, input logic [7:0] rd);
        logic [7:0] opnd;
        logic [7:0] res;
        logic [8:0] s;
        logic       regop, we_e, pcw_e, clr_e;
        // Port addresses take the pin levels, never the latch value on REG_RDATA
        opnd = (ins[4:0] == ADDR_IO_BANK_A) ? PIN_A_IN : (ins[4:0] == ADDR_IO_BANK_B) ? PIN_B_IN :
               (ins[4:0] == ADDR_IO_BANK_C) ? PIN_C_IN : rd;
        regop = (ins[11:6] == OPC_SUM_INTO_TARGET) || (ins[11:6] == OPC_MASK_REGISTER_OP);
        we_e = regop && ins[DEST_BIT];
        if (ins[11:6] == OPC_SUM_INTO_TARGET) begin
            s = {1'b0, acc_m} + {1'b0, opnd};
            res = s[7:0];
            c_m = s[8];
            n_m = ({1'b0, acc_m[3:0]} + {1'b0, opnd[3:0]}) > 5'h0f;
        end else begin
            res = acc_m & opnd;
        end
        if (regop) begin
            z_m = (res == BYTE_ZERO);
            if (ins[DEST_BIT])
                wd_m = res;
            else
                acc_m = res;
        end
        if (ins[11:8] == OPC_MASK_WITH_LITERAL) begin
            acc_m = acc_m & ins[7:0];
            z_m = (acc_m == BYTE_ZERO);
        end
        if (ins[11:3] == OPC_PIN_DIR_LOAD && ins[2:0] >= 3'h5)
            dir_m[ins[2:0] - 3'h5] = acc_m;
        pcw_e = (we_e && ins[4:0] == ADDR_PC_LOW) || (ins[11:9] == OPC_CALL_TOP);
        INSTR <= ins;
        REG_RDATA <= rd;
        INSTR_VALID <= 1'b1;
        @(posedge CLK);
        // Read the prescaler assignment as the design saw it here; a change just before the call lands late
        clr_e = we_e && ins[4:0] == ADDR_TICK_COUNTER && PRESCALER_ON_TICK;
        INSTR_VALID <= 1'b0;
        #1;
        check_state(we_e, pcw_e, clr_e, ins[4:0]);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        do_reset();
        $display("test reset done");
        // Sum into accumulator and register, with carries and a zero result
        run(12'h1c3, 8'h17);
        run(12'h1e3, 8'hc2);
        run(12'h1c3, 8'he9);
        run(12'h1c3, 8'h0f);
        $display("test sum done");
        // Mask ops keep carries and route by target bit
        run(12'h163, 8'hc2);
        run(12'h143, 8'hf0);
        run(12'h1c3, 8'ha3);
        run(12'he5f, 8'h00);
        run(12'he00, 8'h00);
        $display("test mask done");
        // Direction loads for each bank, then a load of non-bank select 4 that must be ignored
        for (int i = 5; i <= 7; i++) begin
            run(12'h1c3, 8'h35 + 8'(i));
            run(12'h000 | 12'(i), 8'h00);
        end
        run(12'h004, 8'h00);
        $display("test direction done");
        // Latch contents on REG_RDATA differ from pins; pins must win
        PIN_A_IN <= 8'h3c;
        PIN_B_IN <= 8'h81;
        PIN_C_IN <= 8'h5a;
        repeat (4) @(posedge CLK);
        #1;
        for (int f = 5; f <= 7; f++)
            run(12'h1c0 | 12'(f), 8'hff);
        run(12'h165, 8'hff);
        run(12'h1e7, 8'h00);
        $display("test pins done");
        // Prescaler clear only for register-targeted writes while assigned
        PRESCALER_ON_TICK <= 1'b1;
        run(12'h1e1, 8'h10);
        run(12'h1c1, 8'h10);
        run(12'h161, 8'h10);
        PRESCALER_ON_TICK <= 1'b0;
        run(12'h1e1, 8'h10);
        $display("test prescaler done");
        // Program counter writes, absolute jump excluded
        run(12'h1e2, 8'h40);
        run(12'h9ab, 8'h00);
        run(12'ha12, 8'h00);
        run(12'h142, 8'h40);
        $display("test pc done");
        // Reset in mid-run restores the idle state
        run(12'h005, 8'h00);
        do_reset();
        run(12'h1c4, 8'h80);
        $display("test second reset done");
        finish_test();
    end
endmodule
`default_nettype wire
